// ==== hw/agoc_ctrl.sv ====
// Purpose: command link controller end: calibration and messages
// Assumes: one engine per link; software reaches it by a plain port
// Notes:   calibration reads both references with calibrate off
module agoc_ctrl (
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  // software port
  input  wire logic [3:0]  sw_addr_in,
  input  wire logic [15:0] sw_wdata_in,
  input  wire logic        sw_wr_in,
  input  wire logic        sw_rd_in,
  output logic      [15:0] sw_rdata_out,
  // reference channel samples
  input  wire logic [11:0] ref_upper_in,
  input  wire logic [11:0] ref_lower_in,
  // command link
  agoc_link_if.ctrl        link
);

  typedef enum logic [6:0] {
    S_IDLE = 7'h01, S_UP = 7'h02, S_LO = 7'h04, S_DIV = 7'h08,
    S_WGAIN = 7'h10, S_WOFF = 7'h20, S_WAIT = 7'h40
  } agoc_ctrl_fsm_t;

  typedef struct packed {
    agoc_ctrl_fsm_t fsm;
    agoc_ctrl_fsm_t after;
    logic        cmd_valid;
    logic [1:0]  cmd_kind;
    logic [7:0]  cmd_addr;
    logic [15:0] cmd_data;
    logic [11:0] cmd_raw;
    logic        cmd_cal;
    logic [14:0] gain;
    logic [13:0] offset;
    logic [13:0] raw_up;
    logic [13:0] raw_lo;
    logic [15:0] result;
    logic [15:0] readback;
    logic        busy;
    logic [31:0] rem;
    logic [31:0] quo;
    logic [5:0]  step;
    logic [15:0] rdata;
  } agoc_ctrl_state_t;

  agoc_ctrl_state_t st;
  agoc_ctrl_state_t next_st;

  // issue one message and wait for its answer
  function automatic agoc_ctrl_state_t send(
    input agoc_ctrl_state_t s, input logic [1:0] kind,
    input logic [7:0] addr, input logic [15:0] data,
    input logic [11:0] raw, input agoc_ctrl_fsm_t ret);
    agoc_ctrl_state_t r;
    r           = s;
    r.cmd_valid = 1'b1;
    r.cmd_kind  = kind;
    r.cmd_addr  = addr;
    r.cmd_data  = data;
    r.cmd_raw   = raw;
    r.cmd_cal   = 1'b0;
    r.after     = ret;
    r.fsm       = S_WAIT;
    return r;
  endfunction : send

  logic [31:0] diff;
  logic [31:0] trial;
  logic [29:0] prod;
  logic [13:0] occ;

  always_comb begin
    diff  = 32'({18'h0, st.raw_up} - {18'h0, st.raw_lo});
    trial = {st.rem[30:0], st.quo[31]};
    prod  = 30'(st.gain) * 30'(st.raw_up);
    // truncating integer form; rounding only matters in float software
    occ   = 14'(agoc_pkg::IDEAL_UPPER_REFERENCE_CODE
               - 14'(prod >> agoc_pkg::GAIN_FRAC_BITS)
               - agoc_pkg::ROUND_TERM);
  end

  // sequencer and software port
  always_comb begin
    next_st           = st;
    next_st.cmd_valid = 1'b0;
    next_st.rdata     = 16'h0000;
    if (sw_rd_in) begin
      unique case (sw_addr_in)
        agoc_pkg::SW_STATUS_ADDR: next_st.rdata = {15'h0, st.busy};
        agoc_pkg::SW_GAIN_ADDR:   next_st.rdata = {1'b0, st.gain};
        agoc_pkg::SW_OFFSET_ADDR: next_st.rdata = {2'b00, st.offset};
        agoc_pkg::SW_RESULT_ADDR: next_st.rdata = st.result;
        agoc_pkg::SW_RAW_UP_ADDR: next_st.rdata = {2'b00, st.raw_up};
        agoc_pkg::SW_RAW_LO_ADDR: next_st.rdata = {2'b00, st.raw_lo};
        agoc_pkg::SW_READBACK_ADDR: next_st.rdata = st.readback;
        default:                  next_st.rdata = 16'h0000;
      endcase
    end
    unique case (st.fsm)
      S_IDLE: begin
        if (sw_wr_in) begin
          unique case (sw_addr_in)
            agoc_pkg::SW_GAIN_ADDR:   next_st.gain = sw_wdata_in[14:0];
            agoc_pkg::SW_OFFSET_ADDR: next_st.offset = sw_wdata_in[13:0];
            agoc_pkg::SW_CONVERT_ADDR: begin
              next_st      = send(next_st, agoc_pkg::CMD_CONVERT, 8'h00,
                                  16'h0000, sw_wdata_in[11:0], S_IDLE);
              next_st.cmd_cal = sw_wdata_in[agoc_pkg::CONV_CAL_BIT];
              next_st.busy = 1'b1;
            end
            agoc_pkg::SW_CTRL_ADDR: begin
              next_st.busy = |sw_wdata_in[3:0];
              if (sw_wdata_in[agoc_pkg::CTRL_START_CAL])
                next_st = send(next_st, agoc_pkg::CMD_CONVERT, 8'h00,
                               16'h0000, ref_upper_in, S_UP);
              else if (sw_wdata_in[agoc_pkg::CTRL_LOAD_COEF])
                next_st.fsm = S_WGAIN;
              else if (sw_wdata_in[agoc_pkg::CTRL_READ_GAIN])
                next_st = send(next_st, agoc_pkg::CMD_READ,
                  agoc_pkg::REG_GAIN_ADDR, 16'h0000, 12'h000, S_IDLE);
              else if (sw_wdata_in[agoc_pkg::CTRL_READ_OFFSET])
                next_st = send(next_st, agoc_pkg::CMD_READ,
                  agoc_pkg::REG_OFFSET_ADDR, 16'h0000, 12'h000, S_IDLE);
            end
            default: ;
          endcase
        end
      end
      S_UP: next_st = send(next_st, agoc_pkg::CMD_CONVERT, 8'h00,
                           16'h0000, ref_lower_in, S_LO);
      S_LO: begin
        next_st.rem  = 32'h0;
        next_st.quo  = agoc_pkg::GAIN_NUMERATOR;
        next_st.step = 6'h00;
        next_st.fsm  = S_DIV;
      end
      S_DIV: begin
        // restoring divide, one quotient bit per cycle
        if (trial >= diff && diff != 32'h0) begin
          next_st.rem = trial - diff;
          next_st.quo = {st.quo[30:0], 1'b1};
        end else begin
          next_st.rem = trial;
          next_st.quo = {st.quo[30:0], 1'b0};
        end
        next_st.step = st.step + 6'h01;
        if (st.step == 6'(agoc_pkg::DIV_STEPS - 1)) begin
          next_st.gain = next_st.quo[14:0];
          next_st.fsm  = S_WOFF;   // offset derived from new gain next
        end
      end
      S_WOFF: begin
        next_st.offset = occ;
        next_st.fsm    = S_WGAIN;
      end
      S_WGAIN: next_st = send(next_st, agoc_pkg::CMD_WRITE,
                   agoc_pkg::REG_GAIN_ADDR, {1'b0, st.gain}, 12'h000,
                   S_IDLE);
      S_WAIT: begin
        if (link.rsp_valid) begin
          next_st.result = link.rsp_data;
          if (st.cmd_kind == agoc_pkg::CMD_READ)
            next_st.readback = link.rsp_data;
          if (st.after == S_UP)
            next_st.raw_up = link.rsp_data[13:0];
          if (st.after == S_LO)
            next_st.raw_lo = link.rsp_data[13:0];
          // gain write chains into offset write
          if (st.cmd_kind == agoc_pkg::CMD_WRITE
              && st.cmd_addr == agoc_pkg::REG_GAIN_ADDR)
            next_st = send(next_st, agoc_pkg::CMD_WRITE,
                agoc_pkg::REG_OFFSET_ADDR, {2'b00, st.offset}, 12'h000,
                S_IDLE);
          else begin
            next_st.fsm  = st.after;
            next_st.busy = (st.after != S_IDLE);
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st          <= '0;
      st.fsm      <= S_IDLE;
      st.after    <= S_IDLE;
      st.gain     <= agoc_pkg::GAIN_RESET;
      st.offset   <= agoc_pkg::OFFSET_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign sw_rdata_out   = st.rdata;
  assign link.cmd_valid = st.cmd_valid;
  assign link.cmd_kind  = st.cmd_kind;
  assign link.cmd_addr  = st.cmd_addr;
  assign link.cmd_data  = st.cmd_data;
  assign link.cmd_raw   = st.cmd_raw;
  assign link.cmd_cal   = st.cmd_cal;

endmodule : agoc_ctrl

// ==== include/agoc_pkg.sv ====
// Purpose: shared constants for the gain/offset correction link
// Assumes: one converter engine per device end, 16-bit register messages
// Notes:   bit 0 of a register is its least significant bit in the lsb-0
//          numbering used for the coefficient layouts
package agoc_pkg;

  // internal register addresses of one engine
  localparam logic [7:0]  REG_GAIN_ADDR     = 8'h04;
  localparam logic [7:0]  REG_OFFSET_ADDR   = 8'h05;

  // message kinds on the command link
  localparam logic [1:0]  CMD_CONVERT       = 2'h0;
  localparam logic [1:0]  CMD_WRITE         = 2'h1;
  localparam logic [1:0]  CMD_READ          = 2'h2;

  // field layout: lsb-0 view of the 16-bit registers
  localparam int          COEF_W            = 14;
  localparam int          GAIN_W            = 15;
  localparam int          GAIN_FRAC_BITS    = 14;
  localparam int          RAW_W             = 12;
  localparam int          RES_W             = 14;
  localparam int          RAW_SHIFT         = 2;
  localparam logic [15:0] GAIN_FIELD_MASK   = 16'h7fff;
  localparam logic [15:0] OFFSET_FIELD_MASK = 16'h3fff;

  // reset values of the coefficients: unity gain, zero offset
  localparam logic [14:0] GAIN_RESET        = 15'h4000;
  localparam logic [13:0] OFFSET_RESET      = 14'h0000;

  // half-lsb rounding term in 14-bit units
  localparam logic [13:0] ROUND_TERM        = 14'h0002;

  // ideal reference codes used by the calibrating controller
  localparam logic [13:0] IDEAL_UPPER_REFERENCE_CODE = 14'h3000;
  localparam logic [13:0] IDEAL_LOWER_REFERENCE_CODE = 14'h1000;
  localparam logic [31:0] GAIN_NUMERATOR    = 32'h0800_0000;

  // controller software register map (word addresses on its plain port)
  localparam logic [3:0]  SW_CTRL_ADDR      = 4'h0;
  localparam logic [3:0]  SW_STATUS_ADDR    = 4'h1;
  localparam logic [3:0]  SW_GAIN_ADDR      = 4'h2;
  localparam logic [3:0]  SW_OFFSET_ADDR    = 4'h3;
  localparam logic [3:0]  SW_RESULT_ADDR    = 4'h4;
  localparam logic [3:0]  SW_RAW_UP_ADDR    = 4'h5;
  localparam logic [3:0]  SW_RAW_LO_ADDR    = 4'h6;
  localparam logic [3:0]  SW_CONVERT_ADDR   = 4'h7;
  localparam logic [3:0]  SW_READBACK_ADDR  = 4'h8;

  // control register bits
  localparam int          CTRL_START_CAL    = 0;
  localparam int          CTRL_LOAD_COEF    = 1;
  localparam int          CTRL_READ_GAIN    = 2;
  localparam int          CTRL_READ_OFFSET  = 3;

  // conversion request field positions (convert register)
  localparam int          CONV_CAL_BIT      = 12;

  // divider length for the gain quotient
  localparam int          DIV_STEPS         = 32;

endpackage : agoc_pkg

// ==== include/agoc_link_if.sv ====
// Purpose: command/result link between controller and correction engine
// Assumes: single clock, one message in flight at a time
// Notes:   the controller drives cmd_*, the engine answers on rsp_*
interface agoc_link_if;
  logic        cmd_valid;
  logic [1:0]  cmd_kind;
  logic [7:0]  cmd_addr;
  logic [15:0] cmd_data;
  logic [11:0] cmd_raw;
  logic        cmd_cal;
  logic        rsp_valid;
  logic [15:0] rsp_data;

  modport engine (
    input  cmd_valid, cmd_kind, cmd_addr, cmd_data, cmd_raw, cmd_cal,
    output rsp_valid, rsp_data
  );

  modport ctrl (
    output cmd_valid, cmd_kind, cmd_addr, cmd_data, cmd_raw, cmd_cal,
    input  rsp_valid, rsp_data
  );
endinterface : agoc_link_if

// ==== hw/agoc_correct.sv ====
// Purpose: arithmetic of the correction: scale, offset, round, clamp
// Assumes: purely combinational, registered by the caller
// Notes:   uncalibrated path still adds the rounding term
module agoc_correct (
  // operands
  input  wire logic [11:0] raw_in,
  input  wire logic [14:0] gain_in,
  input  wire logic [13:0] offset_in,
  input  wire logic        cal_in,
  // result
  output logic      [13:0] result_out
);

  logic [13:0] shifted;
  logic [28:0] product;
  logic [15:0] scaled;
  logic signed [17:0] sum;

  // wide signed sum so that clamping sees the true sign and overflow
  always_comb begin
    shifted = {raw_in, 2'b00};
    product = 29'(shifted) * 29'(gain_in);
    scaled  = cal_in ? 16'(product >> agoc_pkg::GAIN_FRAC_BITS)
                     : {2'b00, shifted};
    sum     = $signed({2'b00, scaled})
            + (cal_in ? 18'($signed(offset_in)) : 18'sd0)
            + $signed({4'h0, agoc_pkg::ROUND_TERM});
    if (sum < 0)
      result_out = 14'h0000;
    else if (sum > 18'sh3fff)
      result_out = 14'h3fff;
    else
      result_out = sum[13:0];
  end

endmodule : agoc_correct

// ==== hw/agoc_engine.sv ====
// Purpose: converter engine end: coefficient registers and correction
// Assumes: controller sends one message at a time, one answer each
// Notes:   answer comes one cycle after the message
module agoc_engine (
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic rst_n_in,
  // command link
  agoc_link_if.engine link
);

  typedef struct packed {
    logic [14:0] gain;
    logic [13:0] offset;
    logic        rsp_valid;
    logic [15:0] rsp_data;
  } agoc_eng_state_t;

  agoc_eng_state_t st;
  agoc_eng_state_t next_st;
  logic [13:0]     corrected;

  // private copies only: another engine instance has its own state
  agoc_correct u_correct (
    .raw_in     (link.cmd_raw),
    .gain_in    (st.gain),
    .offset_in  (st.offset),
    .cal_in     (link.cmd_cal),
    .result_out (corrected)
  );

  // message decode
  always_comb begin
    next_st           = st;
    next_st.rsp_valid = 1'b0;
    next_st.rsp_data  = 16'h0000;
    if (link.cmd_valid) begin
      unique case (link.cmd_kind)
        agoc_pkg::CMD_CONVERT: begin
          next_st.rsp_valid = 1'b1;
          next_st.rsp_data  = {2'b00, corrected};
        end
        agoc_pkg::CMD_WRITE: begin
          next_st.rsp_valid = 1'b1;
          if (link.cmd_addr == agoc_pkg::REG_GAIN_ADDR)
            next_st.gain = link.cmd_data[14:0];
          else if (link.cmd_addr == agoc_pkg::REG_OFFSET_ADDR)
            next_st.offset = link.cmd_data[13:0];
        end
        agoc_pkg::CMD_READ: begin
          next_st.rsp_valid = 1'b1;
          if (link.cmd_addr == agoc_pkg::REG_GAIN_ADDR)
            next_st.rsp_data = {1'b0, st.gain};
          else if (link.cmd_addr == agoc_pkg::REG_OFFSET_ADDR)
            next_st.rsp_data = {2'b00, st.offset};
        end
        default: next_st.rsp_valid = 1'b1;  // unknown kind: empty answer
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.gain      <= agoc_pkg::GAIN_RESET;
      st.offset    <= agoc_pkg::OFFSET_RESET;
      st.rsp_valid <= 1'b0;
      st.rsp_data  <= 16'h0000;
    end else begin
      st <= next_st;
    end
  end

  assign link.rsp_valid = st.rsp_valid;
  assign link.rsp_data  = st.rsp_data;

endmodule : agoc_engine

// ==== sim/agoc_checker.sv ====
// Purpose: link checker for the controller and engine pair
// Assumes: one clock, one message in flight, answer one cycle later
// Notes:   keeps its own copy of the coefficients from write messages
module agoc_checker (
  // clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_n_in,
  // command side
  input wire logic        cmd_valid,
  input wire logic [1:0]  cmd_kind,
  input wire logic [7:0]  cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic [11:0] cmd_raw,
  input wire logic        cmd_cal,
  // answer side
  input wire logic        rsp_valid,
  input wire logic [15:0] rsp_data
);
  logic [14:0] gain_m;
  logic [13:0] off_m;
  logic [13:0] exp_q;
  logic [13:0] next_exp;
  logic        conv;
  logic        wr;
  logic        rd;
  int          sum;

  // message decode
  assign conv = cmd_valid && cmd_kind == agoc_pkg::CMD_CONVERT;
  assign wr   = cmd_valid && cmd_kind == agoc_pkg::CMD_WRITE;
  assign rd   = cmd_valid && cmd_kind == agoc_pkg::CMD_READ;

  // int keeps the sign of the offset; product fits below 2^30
  always_comb begin
    sum = (int'({cmd_raw, 2'h0}) * int'(gain_m)) >>> 14;
    sum = sum + int'($signed(off_m)) + 2;
    if (sum < 0) next_exp = 14'h0000;
    else if (sum > 16383) next_exp = 14'h3fff;
    else next_exp = sum[13:0];
  end

  // coefficient copy and expected calibrated result
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gain_m <= agoc_pkg::GAIN_RESET;
      off_m  <= agoc_pkg::OFFSET_RESET;
      exp_q  <= 14'h0000;
    end else begin
      if (wr && cmd_addr == agoc_pkg::REG_GAIN_ADDR) gain_m <= cmd_data[14:0];
      if (wr && cmd_addr == agoc_pkg::REG_OFFSET_ADDR) off_m <= cmd_data[13:0];
      if (conv) exp_q <= next_exp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  answer_follows_a: assert property (cmd_valid |=> rsp_valid)
    else $error("no answer one cycle after a message");
  answer_once_a: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer held longer than one cycle");
  no_stray_a: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without a message");
  uncal_result_a: assert property (conv && !cmd_cal |=>
    rsp_data == {2'h0, $past(cmd_raw), 2'h0} + 16'h0002)
    else $error("uncalibrated result wrong");
  cal_result_a: assert property (conv && cmd_cal |=>
    rsp_data == {2'h0, exp_q})
    else $error("calibrated result wrong");
  result_range_a: assert property (rsp_valid && $past(conv) |->
    rsp_data[15:14] == 2'h0)
    else $error("result outside 14 bits");
  read_gain_a: assert property (rd && cmd_addr == 8'h04 |=>
    rsp_data == {1'h0, gain_m})
    else $error("gain readback wrong");
  read_offset_a: assert property (rd && cmd_addr == 8'h05 |=>
    rsp_data == {2'h0, off_m})
    else $error("offset readback wrong");

  // main scenarios reached
  cover property (conv && cmd_cal);
  cover property (conv && !cmd_cal);
  cover property (wr && cmd_addr == 8'h04);
  cover property (rd && cmd_addr == 8'h05);
endmodule : agoc_checker

// ==== sim/testbench.sv ====
// Purpose: self-checking bench for the controller and engine pair
// Assumes: 50 MHz clock, reset held 12 cycles
// Notes:   expected values come from an integer model in the bench
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst_n;
  logic [3:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [11:0] ref_up;
  logic [11:0] ref_lo;
  int          n_fail;
  int          tests_run;
  int          seed;
  int          cycles;
  int          g;
  int          o;

  agoc_link_if link ();
  agoc_ctrl agoc_ctrl_inst (.core_clk_in(clk), .rst_n_in(rst_n),
    .sw_addr_in(addr), .sw_wdata_in(wdata), .sw_wr_in(wr), .sw_rd_in(rd),
    .sw_rdata_out(rdata), .ref_upper_in(ref_up), .ref_lower_in(ref_lo),
    .link(link));
  agoc_engine agoc_engine_inst (.core_clk_in(clk), .rst_n_in(rst_n),
    .link(link));
  agoc_checker agoc_checker_inst (.core_clk_in(clk), .rst_n_in(rst_n),
    .cmd_valid(link.cmd_valid), .cmd_kind(link.cmd_kind),
    .cmd_addr(link.cmd_addr), .cmd_data(link.cmd_data),
    .cmd_raw(link.cmd_raw), .cmd_cal(link.cmd_cal),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // software port: one-cycle strobes, read data in the next cycle only
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  // bounded poll of busy; a stuck busy shows as a mismatch
  task automatic idle();
    logic [15:0] d;
    for (int i = 0; i < 100; i++) begin
      rd_reg(agoc_pkg::SW_STATUS_ADDR, d);
      if (d[0] === 1'b0) break;
    end
    chk("busy", {15'h0000, d[0]}, 16'h0000);
  endtask : idle

  // saturating correction, uncalibrated path keeps the rounding term
  function automatic logic [15:0] model(input int raw, input logic cal);
    int s;
    s = cal ? ((raw * 4 * g) >>> 14) + o + 2 : raw * 4 + 2;
    if (s < 0) s = 0;
    if (s > 16383) s = 16383;
    return 16'(s);
  endfunction : model

  task automatic eng_rd(input int b, input logic [15:0] exp, input string w);
    logic [15:0] d;
    wr_reg(agoc_pkg::SW_CTRL_ADDR, 16'(1 << b));
    idle();
    rd_reg(agoc_pkg::SW_READBACK_ADDR, d);
    chk(w, d, exp);
  endtask : eng_rd

  task automatic convert(input logic [11:0] raw, input logic cal);
    logic [15:0] d;
    wr_reg(agoc_pkg::SW_CONVERT_ADDR, {3'h0, cal, raw});
    idle();
    rd_reg(agoc_pkg::SW_RESULT_ADDR, d);
    chk("result", d, model(int'(raw), cal));
  endtask : convert

  // wide values on purpose: upper bits must be dropped
  task automatic load(input logic [15:0] gv, input logic [15:0] ov);
    wr_reg(agoc_pkg::SW_GAIN_ADDR, gv);
    wr_reg(agoc_pkg::SW_OFFSET_ADDR, ov);
    wr_reg(agoc_pkg::SW_CTRL_ADDR, 16'h0002);
    idle();
    g = int'(gv[14:0]);
    o = $signed(ov[13:0]);
    eng_rd(agoc_pkg::CTRL_READ_GAIN, {1'h0, gv[14:0]}, "gain");
    eng_rd(agoc_pkg::CTRL_READ_OFFSET, {2'h0, ov[13:0]}, "offset");
  endtask : load

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      test_done();
    end
  end

  // main sequence
  initial begin
    logic [15:0] d;
    int          ru;
    int          rl;
    seed = 75;
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    ref_up = 12'hc00;
    ref_lo = 12'h400;
    g = 16384;
    o = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    eng_rd(agoc_pkg::CTRL_READ_GAIN, 16'h4000, "reset gain");
    eng_rd(agoc_pkg::CTRL_READ_OFFSET, 16'h0000, "reset offset");
    convert(12'h000, 1'b0);
    convert(12'hfff, 1'b0);
    for (int k = 0; k < 8; k++) begin
      case (k)
        0: load(16'hffff, 16'h1fff);
        1: load(16'h8000, 16'he000);
        default: load(16'($random(seed)), 16'($random(seed)));
      endcase
      convert(12'hfff, 1'b1);
      convert(12'h000, 1'b1);
      for (int i = 0; i < 3; i++) convert(12'($random(seed)), 1'b1);
      convert(12'($random(seed)), 1'b0);
    end
    // full calibration from two reference reads
    for (int k = 0; k < 3; k++) begin
      ref_up <= 12'hc00 + 12'($random(seed) % 16);
      ref_lo <= 12'h400 + 12'($random(seed) % 16);
      wr_reg(agoc_pkg::SW_CTRL_ADDR, 16'h0001);
      idle();
      ru = int'(ref_up) * 4 + 2;
      rl = int'(ref_lo) * 4 + 2;
      rd_reg(agoc_pkg::SW_RAW_UP_ADDR, d);
      chk("raw upper", d, 16'(ru));
      rd_reg(agoc_pkg::SW_RAW_LO_ADDR, d);
      chk("raw lower", d, 16'(rl));
      g = 134217728 / (ru - rl);
      o = 12288 - ((g * ru) >>> 14) - 2;
      eng_rd(agoc_pkg::CTRL_READ_GAIN, 16'(g), "cal gain");
      eng_rd(agoc_pkg::CTRL_READ_OFFSET, {2'h0, 14'(o)}, "cal offset");
      convert(ref_up, 1'b1);
    end
    test_done();
  end
endmodule : testbench
